/* inc/shd_regs.vh */
// Field positions, encodings and status layout of the half-duplex serial block
`ifndef SHD_REGS_VH
`define SHD_REGS_VH
`define SHD_CTRL_EN        31
`define SHD_CTRL_EXTCLK    8
`define SHD_CTRL_MODE_HI   25
`define SHD_CTRL_MODE_LO   24
`define SHD_MODE_SPI       2'h1
`define SHD_SPI_MASTER     31
`define SHD_SPI_SUB_HI     25
`define SHD_SPI_SUB_LO     24
`define SHD_SUB_HALF       2'h2
`define SHD_SPI_SEL_HI     27
`define SHD_SPI_SEL_LO     26
`define SHD_SPI_CLOCK_POLARITY 3
`define SHD_SPI_CLOCK_PHASE    2
`define SHD_TRX_WIDTH_HI   3
`define SHD_TRX_WIDTH_LO   0
`define SHD_TRX_MSB        8
`define SHD_TRX_EN         31
`define SHD_WIDTH_MIN      4'h3
`define SHD_Q_TRIG_HI      2
`define SHD_Q_TRIG_LO      0
`define SHD_Q_CLEAR        16
`define SHD_Q_FREEZE       17
`define SHD_QS_SRV         15
`define SHD_BS_BUSY        0
`define SHD_TXE_TRIG       0
`define SHD_TXE_NOTFULL    1
`define SHD_TXE_EMPTY      2
`define SHD_TXE_OVF        3
`define SHD_TXE_UDF        4
`define SHD_RXE_FULL       0
`define SHD_RXE_NOTEMPTY   1
`define SHD_RXE_OVF        2
`define SHD_RXE_UDF        3
`define SHD_RXE_TRIG       4
`define SHD_EV_DONE        0
`define SHD_EV_BUSERR      1
`define SHD_EV_WAKE        2
`define SHD_EV_STOP        3
`define SHD_EV_STOPWR      4
`define SHD_HALF_BIT       4
`endif

/* rtl/shd_spi_halfduplex.v */
// Half-duplex serial block: queues, link engine, events and interrupts
`timescale 1ns/100ps
`default_nettype none
`include "shd_regs.vh"
// How it works
// - Master sends frame, then receives; never both
// - Send and receive widths set separately
// - One idle bit between send and receive
// - Back-to-back transfers have no idle bit
// - Mode 0: launch on fall, sample on rise
// - Top control mode 01 selects serial protocol
// - Protocol submode 10 selects half duplex
// - All control and status words 32 bits
// - Slave answers only select line zero
// - Protocol control: role, variant, polarity, phase
// - Top control: enable, interface type, clocking
// - Bus status shows transfer in progress
// - Push strobe writes frame into send queue
// - Pop returns oldest frame and removes it
// - Peek shows oldest frame, no removal
// - Queue status: count, pointers, shift valid
// - Send interrupt is OR of enabled sources
// - Receive interrupt is OR of enabled sources
// - Flag master done and unexpected deselect
// - Send events: trigger, not full, empty, over/underflow
// - Receive events: full, not empty, over/underflow
// - External clocking: wake and stop events
// - Frame length is width field plus one; fields below 3 count as 3
// - Trigger compares count against 3-bit level
// - Clear empties queue; freeze stops hardware access
// - Settings apply on enable; enable reinitialises
module shd_spi_halfduplex #(
  parameter FIFO_AW  = 3,
  parameter HALF_BIT = `SHD_HALF_BIT
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire [31:0] block_control_i,
  input  wire [31:0] serial_protocol_control_i,
  input  wire [31:0] transmit_control_i,
  input  wire [31:0] receive_control_i,
  input  wire [31:0] transmit_queue_control_i,
  input  wire [31:0] receive_queue_control_i,
  input  wire        tx_push_i,
  input  wire [15:0] tx_push_data_i,
  input  wire        rx_pop_i,
  input  wire [4:0]  tx_intr_mask_i,
  input  wire [4:0]  rx_intr_mask_i,
  input  wire [4:0]  tx_intr_clear_i,
  input  wire [4:0]  rx_intr_clear_i,
  input  wire [4:0]  spi_event_clear_i,
  input  wire        sclk_i,
  input  wire        mosi_i,
  input  wire        miso_i,
  input  wire        ss_n_i,
  output reg         sclk_o,
  output reg         sclk_oe_o,
  output reg         mosi_o,
  output reg         mosi_oe_o,
  output reg         miso_o,
  output reg         miso_oe_o,
  output reg  [3:0]  ss_n_o,
  output reg  [31:0] serial_bus_status_o,
  output reg  [31:0] transmit_queue_status_o,
  output reg  [31:0] receive_queue_status_o,
  output reg  [15:0] receive_queue_pop_o,
  output reg  [15:0] receive_queue_peek_o,
  output reg  [4:0]  tx_events_o,
  output reg  [4:0]  rx_events_o,
  output reg  [4:0]  spi_events_o,
  output reg         irq_tx_o,
  output reg         irq_rx_o
);
  localparam DEPTH_N = 1 << FIFO_AW;
  localparam [FIFO_AW:0] DEPTH = DEPTH_N[FIFO_AW:0];
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_TX   = 2'h1;
  localparam [1:0] ST_GAP  = 2'h2;
  localparam [1:0] ST_RX   = 2'h3;
  localparam [7:0] HB_LAST = HALF_BIT[7:0] - 8'h1;

  function [3:0] shd_bit_idx;
    input       msb;
    input [3:0] w;
    input [3:0] n;
    begin
      shd_bit_idx = msb ? n : w - n;
    end
  endfunction

  function [31:0] shd_qstat;
    input [FIFO_AW:0]   cnt;
    input [FIFO_AW-1:0] rd;
    input [FIFO_AW-1:0] wr;
    input               srv;
    begin
      shd_qstat = 32'h0;
      shd_qstat[FIFO_AW:0] = cnt;
      shd_qstat[`SHD_QS_SRV] = srv;
      shd_qstat[16 +: FIFO_AW] = rd;
      shd_qstat[24 +: FIFO_AW] = wr;
    end
  endfunction

  // Latched only while disabled; a live change never hits a transfer
  reg [31:0] spi_cfg_r;
  reg [31:0] txc_cfg_r;
  reg [31:0] rxc_cfg_r;
  reg        ext_cfg_r;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_cfg_r <= 32'h0;
      txc_cfg_r <= 32'h0;
      rxc_cfg_r <= 32'h0;
      ext_cfg_r <= 1'b0;
    end else if (!block_control_i[`SHD_CTRL_EN]) begin
      spi_cfg_r <= serial_protocol_control_i;
      txc_cfg_r <= transmit_control_i;
      rxc_cfg_r <= receive_control_i;
      ext_cfg_r <= block_control_i[`SHD_CTRL_EXTCLK];
    end
  end

  wire run_w = block_control_i[`SHD_CTRL_EN] &&
    block_control_i[`SHD_CTRL_MODE_HI:`SHD_CTRL_MODE_LO] == `SHD_MODE_SPI &&
    spi_cfg_r[`SHD_SPI_SUB_HI:`SHD_SPI_SUB_LO] == `SHD_SUB_HALF;
  // Half duplex ignores polarity and phase: always mode 0
  wire       mst_w  = spi_cfg_r[`SHD_SPI_MASTER];
  wire [1:0] sel_w  = spi_cfg_r[`SHD_SPI_SEL_HI:`SHD_SPI_SEL_LO];
  wire [3:0] txw_f  = txc_cfg_r[`SHD_TRX_WIDTH_HI:`SHD_TRX_WIDTH_LO];
  wire [3:0] rxw_f  = rxc_cfg_r[`SHD_TRX_WIDTH_HI:`SHD_TRX_WIDTH_LO];
  wire [3:0] txw_w  = (txw_f < `SHD_WIDTH_MIN) ? `SHD_WIDTH_MIN : txw_f;
  wire [3:0] rxw_w  = (rxw_f < `SHD_WIDTH_MIN) ? `SHD_WIDTH_MIN : rxw_f;
  wire       tmsb_w = txc_cfg_r[`SHD_TRX_MSB];
  wire       rmsb_w = rxc_cfg_r[`SHD_TRX_MSB];
  wire       tx_en_w = txc_cfg_r[`SHD_TRX_EN];
  wire       rx_en_w = rxc_cfg_r[`SHD_TRX_EN];
  wire       tx_clr_w = transmit_queue_control_i[`SHD_Q_CLEAR] || !run_w;
  wire       rx_clr_w = receive_queue_control_i[`SHD_Q_CLEAR] || !run_w;
  wire       tx_frz_w = transmit_queue_control_i[`SHD_Q_FREEZE];
  wire       rx_frz_w = receive_queue_control_i[`SHD_Q_FREEZE];
  wire [2:0] tx_trg_w =
    transmit_queue_control_i[`SHD_Q_TRIG_HI:`SHD_Q_TRIG_LO];
  wire [2:0] rx_trg_w =
    receive_queue_control_i[`SHD_Q_TRIG_HI:`SHD_Q_TRIG_LO];

  // Pin synchronisers; third stage only feeds the edge detectors
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [3:0] pin_s3_r;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= 4'h1;
      pin_s2_r <= 4'h1;
      pin_s3_r <= 4'h1;
    end else begin
      pin_s1_r <= {sclk_i, mosi_i, miso_i, ss_n_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  wire sck_rise_w = pin_s2_r[3] && !pin_s3_r[3];
  wire sck_fall_w = !pin_s2_r[3] && pin_s3_r[3];
  wire mosi_s_w   = pin_s2_r[2];
  wire miso_s_w   = pin_s2_r[1];
  wire ss_s_w     = pin_s2_r[0];

  // Send queue
  reg [15:0]        tx_mem [0:DEPTH_N-1];
  reg [FIFO_AW-1:0] tx_wr_r;
  reg [FIFO_AW-1:0] tx_rd_r;
  reg [FIFO_AW:0]   tx_cnt_r;
  reg               tx_pop_r;
  wire tx_full_w  = tx_cnt_r == DEPTH;
  wire tx_empty_w = tx_cnt_r == {(FIFO_AW+1){1'b0}};
  wire tx_push_w  = tx_push_i && !tx_full_w && run_w;
  wire tx_hpop_w  = tx_pop_r && !tx_frz_w && !tx_empty_w;
  wire [15:0] tx_head_w = tx_mem[tx_rd_r];
  always @(posedge sys_clk_i) begin
    if (tx_push_w)
      tx_mem[tx_wr_r] <= tx_push_data_i;
  end
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_wr_r  <= {FIFO_AW{1'b0}};
      tx_rd_r  <= {FIFO_AW{1'b0}};
      tx_cnt_r <= {(FIFO_AW+1){1'b0}};
    end else if (tx_clr_w) begin
      tx_wr_r  <= {FIFO_AW{1'b0}};
      tx_rd_r  <= {FIFO_AW{1'b0}};
      tx_cnt_r <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (tx_push_w)
        tx_wr_r <= tx_wr_r + 1'b1;
      if (tx_hpop_w)
        tx_rd_r <= tx_rd_r + 1'b1;
      if (tx_push_w && !tx_hpop_w)
        tx_cnt_r <= tx_cnt_r + 1'b1;
      else if (!tx_push_w && tx_hpop_w)
        tx_cnt_r <= tx_cnt_r - 1'b1;
    end
  end

  // Receive queue
  reg [15:0]        rx_mem [0:DEPTH_N-1];
  reg [FIFO_AW-1:0] rx_wr_r;
  reg [FIFO_AW-1:0] rx_rd_r;
  reg [FIFO_AW:0]   rx_cnt_r;
  reg [15:0]        rb_d0_r;
  reg [15:0]        rb_d1_r;
  reg [1:0]         rb_cnt_r;
  wire rx_full_w  = rx_cnt_r == DEPTH;
  wire rx_empty_w = rx_cnt_r == {(FIFO_AW+1){1'b0}};
  wire rx_spop_w  = rx_pop_i && !rx_empty_w && run_w;
  // Two-entry buffer drains into the queue; a full queue stalls it
  wire rb_take_w  = rb_cnt_r != 2'h0 && !rx_full_w && !rx_frz_w;
  always @(posedge sys_clk_i) begin
    if (rb_take_w && !rx_clr_w)
      rx_mem[rx_wr_r] <= rb_d0_r;
  end
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_wr_r  <= {FIFO_AW{1'b0}};
      rx_rd_r  <= {FIFO_AW{1'b0}};
      rx_cnt_r <= {(FIFO_AW+1){1'b0}};
      receive_queue_pop_o  <= 16'h0;
      receive_queue_peek_o <= 16'h0;
    end else if (rx_clr_w) begin
      rx_wr_r  <= {FIFO_AW{1'b0}};
      rx_rd_r  <= {FIFO_AW{1'b0}};
      rx_cnt_r <= {(FIFO_AW+1){1'b0}};
      receive_queue_peek_o <= 16'h0;
    end else begin
      receive_queue_peek_o <= rx_mem[rx_rd_r];
      if (rx_spop_w) begin
        receive_queue_pop_o <= rx_mem[rx_rd_r];
        rx_rd_r <= rx_rd_r + 1'b1;
      end
      if (rb_take_w)
        rx_wr_r <= rx_wr_r + 1'b1;
      if (rb_take_w && !rx_spop_w)
        rx_cnt_r <= rx_cnt_r + 1'b1;
      else if (!rb_take_w && rx_spop_w)
        rx_cnt_r <= rx_cnt_r - 1'b1;
    end
  end

  // Link engine
  reg [1:0]  st_r;
  reg [3:0]  bcnt_r;
  reg [15:0] tx_sr_r;
  reg [15:0] rx_sr_r;
  reg [7:0]  div_r;
  reg        gap_seen_r;
  reg        fresh_r;
  reg        rx_done_r;
  reg [4:0]  ev_pulse_r;
  reg        tx_udf_p_r;
  wire tick_w   = div_r == HB_LAST;
  wire can_go_w = !tx_empty_w && tx_en_w && !tx_frz_w;
  wire [3:0] tbit_n_w = shd_bit_idx(tmsb_w, txw_w, bcnt_r - 1'b1);
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      bcnt_r <= 4'h0;
      tx_sr_r <= 16'h0;
      rx_sr_r <= 16'h0;
      div_r <= 8'h0;
      gap_seen_r <= 1'b0;
      fresh_r <= 1'b0;
      rx_done_r <= 1'b0;
      ev_pulse_r <= 5'h0;
      tx_udf_p_r <= 1'b0;
      tx_pop_r <= 1'b0;
      sclk_o <= 1'b0;
      sclk_oe_o <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      ss_n_o <= 4'hf;
    end else if (!run_w || tx_clr_w && rx_clr_w) begin
      st_r <= ST_IDLE;
      tx_sr_r <= 16'h0;
      rx_sr_r <= 16'h0;
      div_r <= 8'h0;
      rx_done_r <= 1'b0;
      ev_pulse_r <= 5'h0;
      tx_udf_p_r <= 1'b0;
      tx_pop_r <= 1'b0;
      sclk_o <= 1'b0;
      sclk_oe_o <= run_w && mst_w;
      mosi_o <= 1'b0;
      mosi_oe_o <= run_w && mst_w;
      miso_oe_o <= 1'b0;
      ss_n_o <= 4'hf;
    end else if (mst_w) begin
      rx_done_r <= 1'b0;
      ev_pulse_r <= 5'h0;
      tx_pop_r <= 1'b0;
      tx_udf_p_r <= 1'b0;
      sclk_oe_o <= 1'b1;
      mosi_oe_o <= 1'b1;
      miso_oe_o <= 1'b0;
      div_r <= (st_r == ST_IDLE || tick_w) ? 8'h0 : div_r + 8'h1;
      case (st_r)
        ST_IDLE: begin
          sclk_o <= 1'b0;
          if (can_go_w) begin
            tx_sr_r <= tx_head_w;
            tx_pop_r <= 1'b1;
            bcnt_r <= txw_w;
            mosi_o <= tx_head_w[shd_bit_idx(tmsb_w, txw_w, txw_w)];
            ss_n_o <= ~(4'h1 << sel_w);
            st_r <= ST_TX;
          end
        end
        default: begin
          if (tick_w && !sclk_o) begin
            sclk_o <= 1'b1;
            if (st_r == ST_RX)
              rx_sr_r[shd_bit_idx(rmsb_w, rxw_w, bcnt_r)] <= miso_s_w;
          end else if (tick_w) begin
            sclk_o <= 1'b0;
            case (st_r)
              ST_TX: begin
                if (bcnt_r == 4'h0) begin
                  mosi_o <= 1'b0;
                  st_r <= ST_GAP;
                end else begin
                  bcnt_r <= bcnt_r - 4'h1;
                  mosi_o <= tx_sr_r[tbit_n_w];
                end
              end
              ST_GAP: begin
                bcnt_r <= rxw_w;
                rx_sr_r <= 16'h0;
                st_r <= ST_RX;
              end
              default: begin
                if (bcnt_r == 4'h0) begin
                  rx_done_r <= rx_en_w;
                  ev_pulse_r[`SHD_EV_DONE] <= 1'b1;
                  if (can_go_w) begin
                    tx_sr_r <= tx_head_w;
                    tx_pop_r <= 1'b1;
                    bcnt_r <= txw_w;
                    mosi_o <= tx_head_w[shd_bit_idx(tmsb_w, txw_w, txw_w)];
                    st_r <= ST_TX;
                  end else begin
                    ss_n_o <= 4'hf;
                    st_r <= ST_IDLE;
                  end
                end else begin
                  bcnt_r <= bcnt_r - 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end else begin
      // Slave: receive first, then answer after the idle bit
      rx_done_r <= 1'b0;
      ev_pulse_r <= 5'h0;
      tx_pop_r <= 1'b0;
      tx_udf_p_r <= 1'b0;
      sclk_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      ss_n_o <= 4'hf;
      if (st_r == ST_IDLE) begin
        if (!ss_s_w) begin
          ev_pulse_r[`SHD_EV_WAKE] <= ext_cfg_r;
          bcnt_r <= rxw_w;
          rx_sr_r <= 16'h0;
          fresh_r <= 1'b1;
          st_r <= ST_RX;
        end
      end else if (ss_s_w) begin
        // Deselect between frames is a clean stop
        ev_pulse_r[`SHD_EV_BUSERR] <= !fresh_r;
        miso_oe_o <= 1'b0;
        st_r <= ST_IDLE;
      end else begin
        case (st_r)
          ST_RX: begin
            if (sck_rise_w) begin
              rx_sr_r[shd_bit_idx(rmsb_w, rxw_w, bcnt_r)] <= mosi_s_w;
              fresh_r <= 1'b0;
              if (bcnt_r == 4'h0) begin
                rx_done_r <= rx_en_w;
                ev_pulse_r[`SHD_EV_STOPWR] <= ext_cfg_r;
                gap_seen_r <= 1'b0;
                st_r <= ST_GAP;
              end else begin
                bcnt_r <= bcnt_r - 4'h1;
              end
            end
          end
          ST_GAP: begin
            if (sck_rise_w)
              gap_seen_r <= 1'b1;
            else if (sck_fall_w && gap_seen_r) begin
              tx_sr_r <= can_go_w ? tx_head_w : 16'h0;
              tx_pop_r <= can_go_w;
              tx_udf_p_r <= !can_go_w;
              miso_o <= can_go_w &&
                tx_head_w[shd_bit_idx(tmsb_w, txw_w, txw_w)];
              miso_oe_o <= 1'b1;
              bcnt_r <= txw_w;
              st_r <= ST_TX;
            end
          end
          default: begin
            if (sck_fall_w) begin
              if (bcnt_r == 4'h0) begin
                miso_oe_o <= 1'b0;
                ev_pulse_r[`SHD_EV_STOP] <= ext_cfg_r;
                bcnt_r <= rxw_w;
                rx_sr_r <= 16'h0;
                fresh_r <= 1'b1;
                st_r <= ST_RX;
              end else begin
                bcnt_r <= bcnt_r - 4'h1;
                miso_o <= tx_sr_r[tbit_n_w];
              end
            end
          end
        endcase
      end
    end
  end

  // Two-entry receive buffer
  wire rb_put_w  = rx_done_r && (rb_cnt_r != 2'h2 || rb_take_w);
  wire rx_ovf_w  = rx_done_r && !rb_put_w;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rb_cnt_r <= 2'h0;
      rb_d0_r <= 16'h0;
      rb_d1_r <= 16'h0;
    end else if (rx_clr_w) begin
      rb_cnt_r <= 2'h0;
    end else begin
      if (rb_take_w)
        rb_d0_r <= rb_d1_r;
      if (rb_put_w) begin
        if (rb_cnt_r == 2'h0 || rb_cnt_r == 2'h1 && rb_take_w)
          rb_d0_r <= rx_sr_r;
        else
          rb_d1_r <= rx_sr_r;
      end
      rb_cnt_r <= rb_cnt_r + {1'b0, rb_put_w} - {1'b0, rb_take_w};
    end
  end

  // Events, status and interrupts; set wins over clear
  reg tx_ovf_r;
  reg tx_udf_r;
  reg rx_ovf_r;
  reg rx_udf_r;
  reg [4:0] spi_ev_r;
  wire [4:0] tx_live_w;
  wire [4:0] rx_live_w;
  assign tx_live_w = {tx_udf_r, tx_ovf_r, tx_empty_w, !tx_full_w,
    tx_cnt_r < {{(FIFO_AW-2){1'b0}}, tx_trg_w}};
  assign rx_live_w = {rx_cnt_r > {{(FIFO_AW-2){1'b0}}, rx_trg_w},
    rx_udf_r, rx_ovf_r, !rx_empty_w, rx_full_w};
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ovf_r <= 1'b0;
      tx_udf_r <= 1'b0;
      rx_ovf_r <= 1'b0;
      rx_udf_r <= 1'b0;
      spi_ev_r <= 5'h0;
      tx_events_o <= 5'h0;
      rx_events_o <= 5'h0;
      spi_events_o <= 5'h0;
      irq_tx_o <= 1'b0;
      irq_rx_o <= 1'b0;
      serial_bus_status_o <= 32'h0;
      transmit_queue_status_o <= 32'h0;
      receive_queue_status_o <= 32'h0;
    end else begin
      tx_ovf_r <= tx_push_i && tx_full_w ||
        tx_ovf_r && !tx_intr_clear_i[`SHD_TXE_OVF];
      tx_udf_r <= tx_udf_p_r || tx_pop_r && tx_empty_w ||
        tx_udf_r && !tx_intr_clear_i[`SHD_TXE_UDF];
      rx_ovf_r <= rx_ovf_w ||
        rx_ovf_r && !rx_intr_clear_i[`SHD_RXE_OVF];
      rx_udf_r <= rx_pop_i && rx_empty_w ||
        rx_udf_r && !rx_intr_clear_i[`SHD_RXE_UDF];
      spi_ev_r <= ev_pulse_r | (spi_ev_r & ~spi_event_clear_i);
      tx_events_o <= tx_live_w;
      rx_events_o <= rx_live_w;
      spi_events_o <= spi_ev_r;
      irq_tx_o <= |(tx_live_w & tx_intr_mask_i);
      irq_rx_o <= |(rx_live_w & rx_intr_mask_i);
      serial_bus_status_o <= {31'h0, st_r != ST_IDLE};
      transmit_queue_status_o <= shd_qstat(tx_cnt_r, tx_rd_r, tx_wr_r,
        st_r == ST_TX);
      receive_queue_status_o <= shd_qstat(rx_cnt_r, rx_rd_r, rx_wr_r,
        st_r == ST_RX && !fresh_r);
    end
  end
endmodule // shd_spi_halfduplex
`default_nettype wire

/* sim/shd_spi_halfduplex_sva.sv */
// Port timing checker for the half-duplex serial block
`timescale 1ns/100ps
`default_nettype none
module shd_spi_halfduplex_chk (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] block_control_i,
  input wire logic [31:0] serial_protocol_control_i,
  input wire logic        tx_push_i,
  input wire logic        rx_pop_i,
  input wire logic [4:0]  tx_intr_mask_i,
  input wire logic [4:0]  rx_intr_mask_i,
  input wire logic        sclk_o,
  input wire logic        mosi_o,
  input wire logic        miso_oe_o,
  input wire logic [3:0]  ss_n_o,
  input wire logic [31:0] serial_bus_status_o,
  input wire logic [15:0] receive_queue_pop_o,
  input wire logic [4:0]  tx_events_o,
  input wire logic [4:0]  rx_events_o,
  input wire logic        irq_tx_o,
  input wire logic        irq_rx_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ss_idle_off_a: assert property (
    (!block_control_i[31])[*3] |-> ss_n_o == 4'hf && !serial_bus_status_o[0])
    else $error("select or busy while disabled");
  clk_idle_a: assert property ((ss_n_o == 4'hf)[*2] |-> !sclk_o)
    else $error("serial clock high while idle");
  mosi_fall_a: assert property (
    $changed(mosi_o) && !ss_n_o[0] && $past(!ss_n_o[0], 3) |-> $fell(sclk_o))
    else $error("mosi moved off a falling edge");
  sel_busy_a: assert property (
    $fell(ss_n_o[0]) |=> serial_bus_status_o[0])
    else $error("select low without busy");
  miso_quiet_a: assert property (
    serial_protocol_control_i[31] && block_control_i[31] &&
    $past(block_control_i[31], 2) |-> !miso_oe_o)
    else $error("master drives miso");
  slave_sel_a: assert property (
    !serial_protocol_control_i[31] && $past(!serial_protocol_control_i[31], 3)
    |-> ss_n_o == 4'hf)
    else $error("slave drives selects");
  irq_tx_a: assert property (
    irq_tx_o == |(tx_events_o & $past(tx_intr_mask_i)))
    else $error("tx interrupt not masked or");
  irq_rx_a: assert property (
    irq_rx_o == |(rx_events_o & $past(rx_intr_mask_i)))
    else $error("rx interrupt not masked or");
  tx_empty_a: assert property (tx_events_o[2] |-> tx_events_o[1])
    else $error("empty but full");
  rx_full_a: assert property (rx_events_o[0] |-> rx_events_o[1])
    else $error("full but empty");
  ovf_cause_a: assert property ($rose(tx_events_o[3]) |->
    $past(tx_push_i) || $past(tx_push_i, 2) || $past(tx_push_i, 3))
    else $error("overflow without push");
  udf_cause_a: assert property ($rose(rx_events_o[3]) |->
    $past(rx_pop_i) || $past(rx_pop_i, 2) || $past(rx_pop_i, 3))
    else $error("underflow without pop");
  pop_hold_a: assert property ($changed(receive_queue_pop_o) |->
    $past(rx_pop_i) || !$past(block_control_i[31]))
    else $error("pop data moved without pop");
endmodule // shd_spi_halfduplex_chk
bind shd_spi_halfduplex shd_spi_halfduplex_chk chk_i (.*);
`default_nettype wire

/* sim/shd_link_slave.sv */
// Behavioural serial slave facing the block in master role
`timescale 1ns/100ps
`default_nettype none
module shd_link_slave #(
  parameter TW = 8,
  parameter RW = 4
) (
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic        ss_n_i,
  output var  logic        miso_o,
  output var  logic [15:0] got_o,
  output var  logic        got_tgl_o
);
  int          n = 0;
  logic [15:0] sh = 16'h0;
  logic [3:0]  rep = 4'h0;
  initial begin
    miso_o = 1'b0;
    got_o = 16'h0;
    got_tgl_o = 1'b0;
  end
  // Sample on rises: send bits, one idle bit, then reply bits
  always @(posedge sclk_i) begin
    if (!ss_n_i) begin
      n = n + 1;
      if (n <= TW)
        sh = {sh[14:0], mosi_i};
      if (n == TW) begin
        got_o = sh & ((16'h1 << TW) - 16'h1);
        got_tgl_o = ~got_tgl_o;
        rep = sh[3:0] ^ 4'ha;
      end
      if (n == TW + 1 + RW)
        n = 0;
    end
  end
  // Outside the reply the line toggles, so a stale bit never looks valid
  always @(negedge sclk_i) begin
    if (!ss_n_i && n > TW && n <= TW + RW)
      miso_o = rep[TW + RW - n];
    else
      miso_o = ~miso_o;
  end
  always @(posedge ss_n_i)
    n = 0;
endmodule // shd_link_slave
`default_nettype wire

/* sim/test_shd_spi_halfduplex.sv */
// Self-checking bench for the half-duplex serial block
`timescale 1ns/100ps
`default_nettype none
module test_shd_spi_halfduplex;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] block_control_i = '0;
  logic [31:0] serial_protocol_control_i = '0;
  logic [31:0] transmit_control_i = 32'h8000_0107;
  logic [31:0] receive_control_i = 32'h8000_0103;
  logic [31:0] transmit_queue_control_i = 32'h2;
  logic [31:0] receive_queue_control_i = 32'h2;
  logic        tx_push_i = 1'b0, rx_pop_i = 1'b0;
  logic [15:0] tx_push_data_i = '0;
  logic [4:0]  tx_intr_mask_i = '0, rx_intr_mask_i = '0;
  logic [4:0]  tx_intr_clear_i = '0, rx_intr_clear_i = '0;
  logic [4:0]  spi_event_clear_i = '0;
  logic        sclk_i = 1'b0, mosi_i = 1'b0, ss_n_i = 1'b1;
  wire logic   miso_i, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o;
  wire logic   miso_oe_o, irq_tx_o, irq_rx_o, got_tgl;
  wire logic [3:0]  ss_n_o;
  wire logic [31:0] serial_bus_status_o, transmit_queue_status_o;
  wire logic [31:0] receive_queue_status_o;
  wire logic [15:0] receive_queue_pop_o, receive_queue_peek_o, got;
  wire logic [4:0]  tx_events_o, rx_events_o, spi_events_o;
  int          err_count = 0, tests_run = 0, seed = 54432, cyc = 0, i;
  logic [15:0] exp_link[$], exp_pop[$], d;
  logic [3:0]  m;
  logic        pop_q = 1'b0;

  shd_spi_halfduplex dut (.*);
  shd_link_slave #(.TW(8), .RW(4)) peer (.sclk_i(sclk_o), .mosi_i(mosi_o),
    .ss_n_i(ss_n_o[0]), .miso_o(miso_i), .got_o(got), .got_tgl_o(got_tgl));

  always #2 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string msg);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic push(input logic [15:0] v);
    tick(1);
    tx_push_i <= 1'b1;
    tx_push_data_i <= v;
  endtask
  task automatic cfg(input logic [31:0] b, input logic [31:0] s);
    tick(1);
    block_control_i <= b & 32'h7fff_ffff;
    serial_protocol_control_i <= s;
    tick(2);
    block_control_i <= b;
    tick(2);
  endtask
  // Link pins are async, so this driver runs on its own time base
  task automatic slv(input logic [3:0] v, input logic [15:0] t, input int nb);
    #1.3 ss_n_i = 1'b0;
    for (int k = 0; k < nb; k++) begin
      mosi_i = (k < 4) ? v[3-k] : 1'b0;
      #16 sclk_i = 1'b1;
      #14;
      if (k < 4)
        chk({31'h0, miso_oe_o}, 32'h0, "miso early");
      if (k > 4)
        chk({31'h0, miso_o}, {31'h0, t[12-k]}, "slave bit");
      #2 sclk_i = 1'b0;
    end
    #16 ss_n_i = 1'b1;
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    if (pop_q && exp_pop.size() > 0)
      chk(receive_queue_pop_o, exp_pop.pop_front(), "pop data");
    pop_q <= rx_pop_i;
  end
  always @(got_tgl)
    if (exp_link.size() > 0)
      chk(got, exp_link.pop_front(), "link frame");
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] %0t run timed out", $time);
      close_out();
    end
  end

  initial begin
    tick(10);
    rst_i <= 1'b0;
    cfg(32'h8100_0000, 32'h8200_0000);
    for (i = 0; i < 3; i++) begin
      d = 16'($random(seed));
      exp_link.push_back({8'h0, d[7:0]});
      exp_pop.push_back({12'h0, d[3:0] ^ 4'ha});
      push(d);
    end
    tick(1);
    tx_push_i <= 1'b0;
    for (i = 0; i < 4000 && (receive_queue_status_o[3:0] !== 4'h3 ||
         serial_bus_status_o[0] !== 1'b0); i++) tick(1);
    $display("Master transfers done");
    chk({28'h0, receive_queue_status_o[3:0]}, 32'h3, "rx count");
    chk(exp_link.size(), 0, "frames seen");
    chk({31'h0, spi_events_o[0]}, 32'h1, "done event");
    chk({30'h0, sclk_oe_o, mosi_oe_o}, 32'h3, "master drives");
    chk({30'h0, rx_events_o[4], rx_events_o[1]}, 32'h3, "rx flags");
    chk(receive_queue_peek_o, exp_pop[0], "peek");
    rx_intr_mask_i <= 5'h12;
    tick(3);
    chk(receive_queue_peek_o, exp_pop[0], "peek again");
    chk({31'h0, irq_rx_o}, 32'h1, "rx irq");
    exp_pop.push_back(exp_pop[2]);
    for (i = 0; i < 4; i++) begin
      tick(1);
      rx_pop_i <= 1'b1;
    end
    tick(1);
    rx_pop_i <= 1'b0;
    tick(4);
    chk({31'h0, rx_events_o[3]}, 32'h1, "rx underflow");
    rx_intr_clear_i <= 5'h1f;
    tick(1);
    rx_intr_clear_i <= 5'h0;
    tick(3);
    chk({27'h0, rx_events_o}, 32'h0, "rx cleared");
    $display("Receive queue test done");
    transmit_queue_control_i <= 32'h0002_0002;
    for (i = 0; i < 9; i++)
      push(16'($random(seed)));
    tick(1);
    tx_push_i <= 1'b0;
    tick(4);
    chk({27'h0, tx_events_o}, 32'h8, "tx full flags");
    chk({28'h0, transmit_queue_status_o[3:0]}, 32'h8, "tx count");
    chk({31'h0, irq_tx_o}, 32'h0, "tx irq masked");
    tx_intr_mask_i <= 5'h08;
    tick(3);
    chk({31'h0, irq_tx_o}, 32'h1, "tx irq");
    transmit_queue_control_i <= 32'h0003_0002;
    tx_intr_clear_i <= 5'h1f;
    tick(1);
    tx_intr_clear_i <= 5'h0;
    tick(4);
    chk({27'h0, tx_events_o}, 32'h7, "tx cleared");
    transmit_queue_control_i <= 32'h2;
    $display("Transmit queue test done");
    cfg(32'h8100_0100, 32'h0200_0000);
    d = 16'($random(seed));
    push(d);
    tick(1);
    tx_push_i <= 1'b0;
    m = 4'($random(seed));
    slv(m, d, 13);
    tick(10);
    chk({29'h0, spi_events_o[3:1]}, 32'h6, "wake stop no error");
    chk({30'h0, sclk_oe_o, mosi_oe_o}, 32'h0, "slave quiet");
    exp_pop.push_back({12'h0, m});
    rx_pop_i <= 1'b1;
    tick(1);
    rx_pop_i <= 1'b0;
    slv(m, d, 2);
    tick(10);
    chk({31'h0, spi_events_o[1]}, 32'h1, "bus error");
    $display("Slave test done");
    tick(5);
    close_out();
  end
endmodule // test_shd_spi_halfduplex
`default_nettype wire
